// File: rtl/gpio_cell_regs.svh
// Register offsets, field positions and reset values of the I/O logic cell.
`ifndef GPIO_CELL_REGS_SVH
`define GPIO_CELL_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ADDR_WIDTH       12
`define DATA_WIDTH       32
`define CTRL_ADDR        12'h000
`define STATUS_ADDR      12'h004
`define CTRL_RESET       32'h0000_0000
`define READ_ZERO        32'h0000_0000

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define CTL_MODE_LO      0
`define CTL_MODE_HI      1
`define CTL_IN_REG       2
`define CTL_OUT_REG      3
`define CTL_OE_REG       4
`define CTL_IN_FALL      5
`define CTL_OUT_FALL     6
`define CTL_OE_FALL      7
`define CTL_INVERT       8
`define CTL_DUAL_EDGE_IO_IN      9
`define CTL_DUAL_EDGE_IO_OUT     10
`define CTL_ALT_SEL      11
`define CTL_ROUTE_LO     12
`define CTL_ROUTE_HI     13
`define CTL_PIN_USED     14
`define CTL_USER_MODE    15
`define CTL_PULL_DOWN    16
`define CTL_DIFF_PIN     17
`define CTL_WIDTH        18

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define STS_PAD_IN       0
`define STS_RISE_DATA    1
`define STS_FALL_DATA    2
`define STS_PAD_OE       3
`define STS_PAD_OUT      4
`define STS_CONFIGURING  5
`define STS_WIDTH        6

// ----------------------------------------------------------------------------
// Register stages
// ----------------------------------------------------------------------------
`define STG_IN_A         0
`define STG_IN_B         1
`define STG_OUT_A        2
`define STG_OUT_B        3
`define STG_OE           4
`define STG_COUNT        5

`endif

// File: rtl/gpio_cell_pkg.sv
// Types shared by the I/O logic cell modules.
package gpio_cell_pkg;

  typedef enum logic [1:0]
  {
    mode_input,
    mode_output,
    mode_bidir,
    mode_clock
  } pin_mode_type;

  typedef enum logic [1:0]
  {
    route_global_clock,
    route_global_control,
    route_pll_ref,
    route_none
  } alt_route_type;

endpackage

// File: rtl/clock_edge_if.sv
// Edge pulses of a sampled core clock, passed from tracker to register stages.
`timescale 1ns/100ps
interface clock_edge_if;
  logic rise;
  logic fall;
  modport source (output rise, output fall);
  modport sink   (input rise, input fall);
endinterface

// File: rtl/clock_edge_tracker.sv
// Detects rising and falling edges of a core clock sampled on the system clock.
`timescale 1ns/100ps
module clock_edge_tracker
(
  // System
  input  wire logic    clk_in,
  input  wire logic    arst_n_in,
  input  wire logic    ce_in,
  // Sampled clock and edge pulses
  input  wire logic    level_in,
  clock_edge_if.source edge_out
);

  logic prev;
  logic next_prev;

  always_comb
  begin
    next_prev = ce_in ? level_in : prev;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      prev <= 1'b0;
    else
      prev <= next_prev;
  end

  assign edge_out.rise = level_in & ~prev;
  assign edge_out.fall = ~level_in & prev;

endmodule

// File: rtl/edge_stage.sv
// One register stage that loads on the selected edge of its clock.
`timescale 1ns/100ps
module edge_stage
(
  // System
  input  wire logic  clk_in,
  input  wire logic  arst_n_in,
  input  wire logic  ce_in,
  // Edge selection and data
  clock_edge_if.sink edge_in,
  input  wire logic  fall_sel_in,
  input  wire logic  d_in,
  output logic       q_out
);

  logic next_q;

  always_comb
  begin
    next_q = q_out;
    if (ce_in && (fall_sel_in ? edge_in.fall : edge_in.rise))
      next_q = d_in;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      q_out <= 1'b0;
    else
      q_out <= next_q;
  end

endmodule

// File: rtl/gpio_io_logic_cell.sv
// I/O logic cell between core fabric and pad buffer, configured over APB.
//
// Function
// - Cell has input, output and output-enable register stages.
// - Input mode enables receive only, passed through or registered on capture clock.
// - Alternate input path drives its function combinationally, never registered.
// - Dual-edge input samples pad on both capture clock edges, two streams.
// - Output mode enables drive only, passed through or registered on drive clock.
// - Optional inversion of the registered output value in output and bidirectional.
// - Dual-edge output captures two bits on both drive edges, muxed onto pad when the output is registered.
// - Bidirectional: input stage on capture clock, output and enable on drive clock.
// - Bidirectional receive and drive paths choose registering independently.
// - Single-rate input, output and enable stages select rising or falling edge of their clock; dual-edge second stages use falling.
// - Clock-output mode drives the core tree clock onto the pad.
// - During configuration ordinary pins use weak pull-up, driver off.
// - During configuration differential-capable pins float, no pulls.
// - Unused pins after configuration tri-state with pull-up, or pull-down option.
// - Alternate input routes only to global clock, global control or PLL input.
// - Dual-edge input: rising sample on first bit, falling on second.
`timescale 1ns/100ps
`include "gpio_cell_regs.svh"
module gpio_io_logic_cell
  import gpio_cell_pkg::*;
(
  // System
  input  wire logic                    clk_in,
  input  wire logic                    arst_n_in,
  input  wire logic                    ce_in,
  // APB slave
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [`ADDR_WIDTH-1:0]  paddr_in,
  input  wire logic [`DATA_WIDTH-1:0]  pwdata_in,
  output logic      [`DATA_WIDTH-1:0]  prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  // Core fabric side
  input  wire logic                    core_out_in,
  input  wire logic                    core_out_fall_in,
  input  wire logic                    core_oe_in,
  input  wire logic                    capture_clock_in,
  input  wire logic                    drive_clock_in,
  input  wire logic                    tree_clock_in,
  output logic                         rise_capture_data_out,
  output logic                         fall_capture_data_out,
  // Alternate input destinations
  output logic                         global_clock_net_out,
  output logic                         global_control_net_out,
  output logic                         pll_reference_input_out,
  // Pad buffer
  input  wire logic                    pad_in,
  output logic                         pad_out,
  output logic                         pad_oe_out,
  output logic                         pull_up_out,
  output logic                         pull_down_out
);

  // --------------------------------------------------------------------------
  // Configuration register and APB access
  // --------------------------------------------------------------------------
  logic [`CTL_WIDTH-1:0]  ctrl;
  logic [`CTL_WIDTH-1:0]  next_ctrl;
  logic [`DATA_WIDTH-1:0] next_prdata;
  logic [`STS_WIDTH-1:0]  status;
  logic                   setup;
  logic                   access;
  logic                   mapped;

  assign setup  = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign mapped = (paddr_in == `CTRL_ADDR) || (paddr_in == `STATUS_ADDR);

  // Read data is latched in the setup cycle so the access phase needs no wait.
  always_comb
  begin
    next_ctrl   = ctrl;
    next_prdata = prdata_out;
    if (ce_in && setup && !pwrite_in)
    begin
      if (paddr_in == `CTRL_ADDR)
        next_prdata = {{(`DATA_WIDTH-`CTL_WIDTH){1'b0}}, ctrl};
      else if (paddr_in == `STATUS_ADDR)
        next_prdata = {{(`DATA_WIDTH-`STS_WIDTH){1'b0}}, status};
      else
        next_prdata = `READ_ZERO;
    end
    if (ce_in && access && pwrite_in && paddr_in == `CTRL_ADDR)
      next_ctrl = pwdata_in[`CTL_WIDTH-1:0];
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl       <= `CTL_WIDTH'(`CTRL_RESET);
      prdata_out <= `READ_ZERO;
    end
    else
    begin
      ctrl       <= next_ctrl;
      prdata_out <= next_prdata;
    end
  end

  assign pready_out  = access & ce_in;
  assign pslverr_out = access & ce_in & ~mapped;

  // --------------------------------------------------------------------------
  // Decoded configuration
  // --------------------------------------------------------------------------
  pin_mode_type  mode;
  alt_route_type route;
  logic          user_mode;
  logic          active;
  logic          rx_on;
  logic          tx_on;

  assign mode      = pin_mode_type'(ctrl[`CTL_MODE_HI:`CTL_MODE_LO]);
  assign route     = alt_route_type'(ctrl[`CTL_ROUTE_HI:`CTL_ROUTE_LO]);
  assign user_mode = ctrl[`CTL_USER_MODE];
  assign active    = user_mode & ctrl[`CTL_PIN_USED];
  assign rx_on     = active & ((mode == mode_input) | (mode == mode_bidir));
  assign tx_on     = active & ((mode == mode_output) | (mode == mode_bidir));

  // --------------------------------------------------------------------------
  // Register stages
  // --------------------------------------------------------------------------
  clock_edge_if capture_edges ();
  clock_edge_if drive_edges ();
  logic [`STG_COUNT-1:0] stg_d;
  logic [`STG_COUNT-1:0] stg_fall;
  logic [`STG_COUNT-1:0] stg_q;

  clock_edge_tracker capture_tracker
  (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .ce_in     (ce_in),
    .level_in  (capture_clock_in),
    .edge_out  (capture_edges)
  );

  clock_edge_tracker drive_tracker
  (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .ce_in     (ce_in),
    .level_in  (drive_clock_in),
    .edge_out  (drive_edges)
  );

  always_comb
  begin
    stg_d              = '0;
    stg_fall           = '0;
    stg_d[`STG_IN_A]   = pad_in;
    stg_fall[`STG_IN_A] = ctrl[`CTL_DUAL_EDGE_IO_IN] ? 1'b0 : ctrl[`CTL_IN_FALL];
    stg_d[`STG_IN_B]   = pad_in;
    stg_fall[`STG_IN_B] = 1'b1;
    stg_d[`STG_OUT_A]  = core_out_in;
    stg_fall[`STG_OUT_A] = ctrl[`CTL_DUAL_EDGE_IO_OUT] ? 1'b0 : ctrl[`CTL_OUT_FALL];
    stg_d[`STG_OUT_B]  = core_out_fall_in;
    stg_fall[`STG_OUT_B] = 1'b1;
    stg_d[`STG_OE]     = core_oe_in;
    stg_fall[`STG_OE]  = ctrl[`CTL_OE_FALL];
  end

  genvar g;
  generate
    for (g = 0; g < `STG_COUNT; g++)
    begin : stage
      if (g < `STG_OUT_A)
      begin : on_capture
        edge_stage reg_stage
        (
          .clk_in      (clk_in),
          .arst_n_in   (arst_n_in),
          .ce_in       (ce_in),
          .edge_in     (capture_edges),
          .fall_sel_in (stg_fall[g]),
          .d_in        (stg_d[g]),
          .q_out       (stg_q[g])
        );
      end
      else
      begin : on_drive
        edge_stage reg_stage
        (
          .clk_in      (clk_in),
          .arst_n_in   (arst_n_in),
          .ce_in       (ce_in),
          .edge_in     (drive_edges),
          .fall_sel_in (stg_fall[g]),
          .d_in        (stg_d[g]),
          .q_out       (stg_q[g])
        );
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Receive path and alternate input
  // --------------------------------------------------------------------------
  logic alt_on;

  assign alt_on = active & (mode == mode_input) & ctrl[`CTL_ALT_SEL];

  always_comb
  begin
    rise_capture_data_out = 1'b0;
    fall_capture_data_out = 1'b0;
    if (rx_on && !alt_on)
    begin
      if (ctrl[`CTL_DUAL_EDGE_IO_IN])
      begin
        rise_capture_data_out = stg_q[`STG_IN_A];
        fall_capture_data_out = stg_q[`STG_IN_B];
      end
      else if (ctrl[`CTL_IN_REG])
        rise_capture_data_out = stg_q[`STG_IN_A];
      else
        rise_capture_data_out = pad_in;
    end
  end

  assign global_clock_net_out    = alt_on & (route == route_global_clock) & pad_in;
  assign global_control_net_out  = alt_on & (route == route_global_control) & pad_in;
  assign pll_reference_input_out = alt_on & (route == route_pll_ref) & pad_in;

  // --------------------------------------------------------------------------
  // Drive path and pad control
  // --------------------------------------------------------------------------
  logic reg_out;
  logic out_val;
  logic oe_val;

  assign reg_out = (ctrl[`CTL_DUAL_EDGE_IO_OUT] && !drive_clock_in) ? stg_q[`STG_OUT_B]
                                                          : stg_q[`STG_OUT_A];
  assign out_val = ctrl[`CTL_OUT_REG] ? (reg_out ^ ctrl[`CTL_INVERT]) : core_out_in;
  assign oe_val  = ctrl[`CTL_OE_REG] ? stg_q[`STG_OE] : core_oe_in;

  always_comb
  begin
    pad_out       = 1'b0;
    pad_oe_out    = 1'b0;
    pull_up_out   = 1'b0;
    pull_down_out = 1'b0;
    if (!user_mode)
    begin
      pull_up_out = ~ctrl[`CTL_DIFF_PIN];
    end
    else if (!ctrl[`CTL_PIN_USED])
    begin
      pull_up_out   = ~ctrl[`CTL_PULL_DOWN];
      pull_down_out = ctrl[`CTL_PULL_DOWN];
    end
    else if (mode == mode_clock)
    begin
      pad_out    = tree_clock_in;
      pad_oe_out = 1'b1;
    end
    else if (tx_on)
    begin
      pad_oe_out = (mode == mode_output) | oe_val;
      pad_out    = pad_oe_out & out_val;
    end
  end

  assign status = {~user_mode, pad_out, pad_oe_out, fall_capture_data_out,
                   rise_capture_data_out, pad_in};

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_config_pull_up: assert property (!user_mode && !ctrl[`CTL_DIFF_PIN] |->
    pull_up_out && !pull_down_out && !pad_oe_out) else $error("config pull-up lost");
  a_config_diff_float: assert property (!user_mode && ctrl[`CTL_DIFF_PIN] |->
    !pull_up_out && !pull_down_out && !pad_oe_out) else $error("diff pin not floating");
  a_unused_pin_pull: assert property (user_mode && !ctrl[`CTL_PIN_USED] |->
    !pad_oe_out && (pull_down_out == ctrl[`CTL_PULL_DOWN]) && (pull_up_out != pull_down_out))
    else $error("unused pin pull wrong");
  a_oe_low_float: assert property (tx_on && mode == mode_bidir && !oe_val |->
    !pad_oe_out && !pad_out) else $error("driver on while enable low");
  a_alt_comb_path: assert property (alt_on && route == route_global_clock |->
    global_clock_net_out == pad_in && !rise_capture_data_out) else $error("alt path wrong");
  a_rise_sample: assert property (rx_on && !alt_on && ctrl[`CTL_DUAL_EDGE_IO_IN] && ce_in &&
    capture_edges.rise ##1 $stable(ctrl) |-> rise_capture_data_out == $past(pad_in))
    else $error("rising sample wrong");
  a_fall_sample: assert property (rx_on && !alt_on && ctrl[`CTL_DUAL_EDGE_IO_IN] && ce_in &&
    capture_edges.fall ##1 $stable(ctrl) |-> fall_capture_data_out == $past(pad_in))
    else $error("falling sample wrong");
  a_out_invert: assert property (tx_on && mode == mode_output && ctrl[`CTL_OUT_REG] &&
    !ctrl[`CTL_DUAL_EDGE_IO_OUT] && ce_in && (ctrl[`CTL_OUT_FALL] ? drive_edges.fall
    : drive_edges.rise) ##1 $stable(ctrl) |-> pad_out == ($past(core_out_in)
    ^ ctrl[`CTL_INVERT])) else $error("registered output wrong");
  a_clock_out: assert property (active && mode == mode_clock |->
    pad_oe_out && pad_out == tree_clock_in) else $error("clock output wrong");
  a_input_only: assert property (active && mode == mode_input |->
    !pad_oe_out) else $error("input mode drives pad");

  c_dual_edge_io_in: cover property (rx_on && ctrl[`CTL_DUAL_EDGE_IO_IN] && capture_edges.fall);
  c_bidir_drive: cover property (tx_on && mode == mode_bidir && pad_oe_out);
  c_ctrl_write: cover property (pready_out && pwrite_in && !pslverr_out);

endmodule

// File: verif/pad_board_model.sv
// Board-side model of the pad line: cell driver, board driver, weak pulls or a floating line.
`timescale 1ns/100ps
module pad_board_model
(
  // System
  input  wire logic clk_in,
  // Board driver
  input  wire logic drive_en_in,
  input  wire logic drive_val_in,
  // Cell pad buffer
  input  wire logic pad_out_in,
  input  wire logic pad_oe_in,
  input  wire logic pull_up_in,
  input  wire logic pull_down_in,
  output logic      pad_level_out
);
  logic float_bit;

  // A line that nobody holds wanders, so a stale level never passes for a drive.
  // The first edge settles the unknown start value to a known level.
  always_ff @(posedge clk_in)
    float_bit <= (float_bit === 1'b1) ? 1'b0 : 1'b1;

  always_comb
  begin
    if (pad_oe_in)
      pad_level_out = pad_out_in;
    else if (drive_en_in)
      pad_level_out = drive_val_in;
    else if (pull_up_in)
      pad_level_out = 1'b1;
    else if (pull_down_in)
      pad_level_out = 1'b0;
    else
      pad_level_out = float_bit;
  end
endmodule

// File: verif/gpio_io_logic_cell_tb.sv
// Self-checking bench for the I/O logic cell through APB, core pins and the pad.
`timescale 1ns/100ps
`include "gpio_cell_regs.svh"
module gpio_io_logic_cell_tb;
  localparam logic [31:0] LIVE = 32'h0000_C000;
  logic        clk_in, arst_n_in = 1'b0, ce_in = 1'b1;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rdata;
  logic        pready_out, pslverr_out, err;
  logic        core_out_in = 1'b0, core_out_fall_in = 1'b0, core_oe_in = 1'b0;
  logic        capture_clock_in = 1'b0, drive_clock_in = 1'b0, tree_clock_in = 1'b0;
  logic        rise_capture_data_out, fall_capture_data_out;
  logic        global_clock_net_out, global_control_net_out, pll_reference_input_out;
  logic        pad_in, pad_out, pad_oe_out, pull_up_out, pull_down_out;
  logic        board_en = 1'b0, board_val = 1'b0;
  int          miscompares = 0, cmp_count = 0;

  gpio_io_logic_cell dut
  (
    .clk_in, .arst_n_in, .ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .core_out_in, .core_out_fall_in, .core_oe_in,
    .capture_clock_in, .drive_clock_in, .tree_clock_in, .rise_capture_data_out,
    .fall_capture_data_out, .global_clock_net_out, .global_control_net_out,
    .pll_reference_input_out, .pad_in, .pad_out, .pad_oe_out, .pull_up_out, .pull_down_out
  );

  pad_board_model board
  (
    .clk_in, .drive_en_in(board_en), .drive_val_in(board_val), .pad_out_in(pad_out),
    .pad_oe_in(pad_oe_out), .pull_up_in(pull_up_out), .pull_down_in(pull_down_out),
    .pad_level_out(pad_in)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do
      @(posedge clk_in);
    while (pready_out !== 1'b1);
    rdata = prdata_out;
    err   = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic cfg(input logic [31:0] v);
    apb(1'b1, `CTRL_ADDR, v);
  endtask

  // Each level change of a core clock is given time to be sampled and to load a stage.
  task automatic clks(input logic c, input logic d);
    capture_clock_in <= c;
    drive_clock_in   <= d;
    step(4);
  endtask

  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    step(3000);
    miscompares++;
    summarize();
  end

  initial
  begin
    step(10);
    arst_n_in <= 1'b1;
    step(1);
    chk_bit("pull_up", 1'b1, pull_up_out);
    chk_bit("pad_oe", 1'b0, pad_oe_out);
    apb(1'b0, `STATUS_ADDR, 32'h0000_0000);
    chk_bit("configuring", 1'b1, rdata[`STS_CONFIGURING]);
    chk_bit("status_pad", 1'b1, rdata[`STS_PAD_IN]);
    cfg(32'h0002_0000);
    step(1);
    chk_bit("pull_up", 1'b0, pull_up_out);
    chk_bit("pull_down", 1'b0, pull_down_out);
    chk_bit("pad_oe", 1'b0, pad_oe_out);
    cfg(32'h0000_8000);
    step(1);
    chk_bit("pull_up", 1'b1, pull_up_out);
    cfg(32'h0001_8000);
    step(1);
    chk_bit("pull_down", 1'b1, pull_down_out);
    chk_bit("pull_up", 1'b0, pull_up_out);
    apb(1'b1, `STATUS_ADDR, 32'hFFFF_FFFF);
    chk_bit("status_err", 1'b0, err);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    chk_bit("unmapped_err", 1'b1, err);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk_word("unmapped_rd", 32'h0000_0000, rdata);
    apb(1'b0, `CTRL_ADDR, 32'h0000_0000);
    chk_word("ctrl", 32'h0001_8000, rdata);
    cfg(LIVE);
    board_en  <= 1'b1;
    board_val <= 1'b1;
    @(negedge clk_in);
    chk_bit("rise_data", 1'b1, rise_capture_data_out);
    chk_bit("pad_oe", 1'b0, pad_oe_out);
    @(posedge clk_in);
    board_val <= 1'b0;
    @(negedge clk_in);
    chk_bit("rise_data", 1'b0, rise_capture_data_out);
    @(posedge clk_in);
    for (int f = 0; f < 2; f++)
    begin
      cfg(LIVE | 32'h0000_0004 | (f ? 32'h0000_0020 : 32'h0000_0000));
      clks(1'b1, 1'b0);
      clks(1'b0, 1'b0);
      board_val <= 1'b1;
      clks(1'b1, 1'b0);
      chk_bit("rise_data", f == 0, rise_capture_data_out);
      clks(1'b0, 1'b0);
      chk_bit("rise_data", 1'b1, rise_capture_data_out);
      board_val <= 1'b0;
    end
    for (int r = 0; r < 4; r++)
    begin
      cfg(LIVE | 32'h0000_0800 | (r << 12));
      board_val <= 1'b1;
      step(1);
      chk_bit("alt_global_clock_net", r == 0, global_clock_net_out);
      chk_bit("alt_global_control_net", r == 1, global_control_net_out);
      chk_bit("alt_pll", r == 2, pll_reference_input_out);
      board_val <= 1'b0;
      @(negedge clk_in);
      chk_bit("alt_nets", 1'b0, global_clock_net_out | global_control_net_out
              | pll_reference_input_out);
      @(posedge clk_in);
    end
    cfg(LIVE | 32'h0000_0200);
    for (int v = 0; v < 2; v++)
    begin
      board_val <= v[0];
      clks(1'b1, 1'b0);
      board_val <= ~v[0];
      clks(1'b0, 1'b0);
      chk_bit("rise_data", v[0], rise_capture_data_out);
      chk_bit("fall_data", ~v[0], fall_capture_data_out);
    end
    board_en <= 1'b0;
    cfg(LIVE | 32'h0000_0101);
    core_out_in <= 1'b1;
    @(negedge clk_in);
    chk_bit("pad_oe", 1'b1, pad_oe_out);
    chk_bit("pad_out", 1'b1, pad_out);
    @(posedge clk_in);
    for (int g = 0; g < 2; g++)
    begin
      cfg(LIVE | 32'h0000_0109 | (g ? 32'h0000_0040 : 32'h0000_0000));
      core_out_in <= 1'b1;
      clks(1'b0, 1'b1);
      clks(1'b0, 1'b0);
      core_out_in <= 1'b0;
      clks(1'b0, 1'b1);
      chk_bit("pad_out", g == 0, pad_out);
      clks(1'b0, 1'b0);
      chk_bit("pad_out", 1'b1, pad_out);
    end
    cfg(LIVE | 32'h0000_0409);
    core_out_in <= 1'b1;
    core_out_fall_in <= 1'b0;
    clks(1'b0, 1'b1);
    chk_bit("pad_out", 1'b1, pad_out);
    clks(1'b0, 1'b0);
    chk_bit("pad_out", 1'b0, pad_out);
    cfg(LIVE | 32'h0000_0016);
    core_oe_in  <= 1'b0;
    core_out_in <= 1'b1;
    clks(1'b0, 1'b1);
    chk_bit("pad_oe", 1'b0, pad_oe_out);
    chk_bit("pad_out", 1'b0, pad_out);
    core_oe_in <= 1'b1;
    clks(1'b1, 1'b0);
    chk_bit("pad_oe", 1'b0, pad_oe_out);
    clks(1'b0, 1'b1);
    chk_bit("pad_oe", 1'b1, pad_oe_out);
    core_out_in <= 1'b0;
    @(negedge clk_in);
    chk_bit("pad_out", 1'b0, pad_out);
    @(posedge clk_in);
    ce_in      <= 1'b0;
    core_oe_in <= 1'b0;
    clks(1'b0, 1'b0);
    clks(1'b0, 1'b1);
    chk_bit("pad_oe_frozen", 1'b1, pad_oe_out);
    core_oe_in <= 1'b1;
    ce_in      <= 1'b1;
    step(1);
    apb(1'b0, `STATUS_ADDR, 32'h0000_0000);
    chk_bit("status_oe", 1'b1, rdata[`STS_PAD_OE]);
    chk_bit("configuring", 1'b0, rdata[`STS_CONFIGURING]);
    cfg(LIVE | 32'h0000_0003);
    for (int t = 0; t < 2; t++)
    begin
      tree_clock_in <= ~t[0];
      @(negedge clk_in);
      chk_bit("pad_out", ~t[0], pad_out);
      chk_bit("pad_oe", 1'b1, pad_oe_out);
      @(posedge clk_in);
    end
    summarize();
  end
endmodule
